//--- logic/acs_clock_control.sv
// Summary of operation
// RULE1: Route 00 drives clock C from synthesizer, 11 from S/PDIF recovery.
// RULE2: Master-out halving bit set gives master output at half input.
// RULE3: Crystal halving bit set halves crystal into synthesizer reference.
// RULE4: Clock C rate bit 0 selects 512 fs, 1 selects 256 fs.
// RULE5: Synth B base rate: 00 48k, 10 32k, 11 44.1k.
// RULE6: Synth B oversample bit: 0 is 256 fs, 1 is 384 fs.
// RULE7: Synth B doubling bit doubles its selected sample rate.
// RULE8: Synth A base rate: 00 48k, 10 32k, 11 44.1k.
// RULE9: Synth A oversample bit: 0 is 256 fs, 1 is 384 fs.
// RULE10: Synth A doubling bit doubles its selected sample rate.
// RULE11: Playback clock source: crystal, master, synth A/B, receiver 512/256.
// RULE12: Record clock source uses the same three-bit encoding.
// RULE13: Internal clock B: crystal, master, synth A or synth B.
// RULE14: Internal clock A: crystal, master, synth A or synth B.
// RULE15: Synth B picks FS2, FS2/2, FS3, FS3/2; synth A FS1 or FS1/2.
// RULE16: Synth B reference: 0 crystal, 1 master clock input.
// RULE17: Synth A reference: 0 crystal, 1 master clock input.
// RULE18: Receiver power-down bit stops the S/PDIF receiver.
// RULE19: Clock output enables are active low, 1 disables.
// RULE20: Synth or oscillator power-down stops that source and its clocks.
// RULE21: Host keeps reserved codes out and reserved bits zero.
`default_nettype none
module acs_clock_control
(
   // Clock and reset
   input  wire logic            clk_in,
   input  wire logic            rst_n_in,
   // Control port
   input  wire acs_pkg::acs_bus_req_type req_in,
   output acs_pkg::acs_bus_rsp_type      rsp_out,
   // Source ticks
   input  wire acs_pkg::acs_ticks_type   ticks_in,
   // Synthesizer and power controls
   output logic [31:0]          synth_a_freq_out,
   output logic [31:0]          synth_b_freq_out,
   output logic [9:0]           sysclk_c_mult_out,
   output logic                 synth_a_ref_tick_out,
   output logic                 synth_b_ref_tick_out,
   output logic                 synth_a_pd_out,
   output logic                 synth_b_pd_out,
   output logic                 osc_pd_out,
   output logic                 receiver_pd_out,
   // Derived clocks
   output logic                 playback_tick_out,
   output logic                 record_tick_out,
   output logic                 internal_a_tick_out,
   output logic                 internal_b_tick_out,
   output logic                 master_clock_out_tick_out,
   output logic                 sysclk_a_tick_out,
   output logic                 sysclk_b_tick_out,
   output logic                 sysclk_c_tick_out
);
   import acs_pkg::*;

   acs_state_type s_r;
   acs_state_type s_nxt;
   acs_regs_type  cfg;

   logic xtal_t;
   logic xtal_ref_t;
   logic mclk_t;
   logic sa_t;
   logic sb_t;
   logic sb3_t;
   logic rx512_t;
   logic rx256_t;
   logic sa_half_t;
   logic sb_half_t;
   logic sb3_half_t;
   logic sa_int_t;
   logic sb_int_t;
   logic sc_src_t;
   logic [1:0] route;

   assign cfg = s_r.regs;

   // ---------------------------------------------
   // Rate arithmetic
   // ---------------------------------------------
   function automatic logic [31:0] rate_hz
   (
      input logic [1:0] base,
      input logic       ovs,
      input logic       dbl
   );
      logic [31:0] fs;
      fs = HZ_48K;
      // Reserved code 01 falls back to 48k
      if (base == BASE_32)
      begin
         fs = HZ_32K;
      end
      else if (base == BASE_441)
      begin
         fs = HZ_441K;
      end
      if (dbl)
      begin
         fs = fs << 1;
      end
      // 384 fs is 256 fs plus 128 fs
      if (ovs)
      begin
         rate_hz = (fs << 8) + (fs << 7);
      end
      else
      begin
         rate_hz = fs << 8;
      end
   endfunction : rate_hz

   function automatic logic conv_pick
   (
      input logic [2:0] code,
      input logic       xt,
      input logic       mc,
      input logic       ia,
      input logic       ib,
      input logic       r5,
      input logic       r2
   );
      // Codes 110 and 111 fall to crystal
      conv_pick = xt;
      if (code == SRC_MCLK)
      begin
         conv_pick = mc;
      end
      else if (code == SRC_SA)
      begin
         conv_pick = ia;
      end
      else if (code == SRC_SB)
      begin
         conv_pick = ib;
      end
      else if (code == SRC_R512)
      begin
         conv_pick = r5;
      end
      else if (code == SRC_R256)
      begin
         conv_pick = r2;
      end
   endfunction : conv_pick

   // ---------------------------------------------
   // Register file and control port
   // ---------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rsp.rd_valid = 1'b0;
      if (req_in.wr_en)
      begin
         if (req_in.addr == ADDR_PDR)
         begin
            s_nxt.regs.pdr = req_in.wdata;
         end
         else if (req_in.addr == ADDR_RATE)
         begin
            s_nxt.regs.rate = req_in.wdata;
         end
         else if (req_in.addr == ADDR_CONV)
         begin
            s_nxt.regs.conv = req_in.wdata;
         end
         else if (req_in.addr == ADDR_INTC)
         begin
            s_nxt.regs.intc = req_in.wdata & MASK_INTC;
         end
         else if (req_in.addr == ADDR_REF)
         begin
            s_nxt.regs.ref_sel = req_in.wdata & MASK_REF;
         end
         else if (req_in.addr == ADDR_OE)
         begin
            s_nxt.regs.oe = req_in.wdata & MASK_OE;
         end
      end
      if (req_in.rd_en)
      begin
         s_nxt.rsp.rd_valid = 1'b1;
         s_nxt.rsp.rd_data = 8'h00;
         if (req_in.addr == ADDR_PDR)
         begin
            s_nxt.rsp.rd_data = cfg.pdr;
         end
         else if (req_in.addr == ADDR_RATE)
         begin
            s_nxt.rsp.rd_data = cfg.rate;
         end
         else if (req_in.addr == ADDR_CONV)
         begin
            s_nxt.rsp.rd_data = cfg.conv;
         end
         else if (req_in.addr == ADDR_INTC)
         begin
            s_nxt.rsp.rd_data = cfg.intc;
         end
         else if (req_in.addr == ADDR_REF)
         begin
            s_nxt.rsp.rd_data = cfg.ref_sel;
         end
         else if (req_in.addr == ADDR_OE)
         begin
            s_nxt.rsp.rd_data = cfg.oe;
         end
      end
      s_nxt.freq_a = rate_hz(cfg.rate[RATE_A_HI:RATE_A_LO],
                             cfg.rate[RATE_A_OVS],
                             cfg.rate[RATE_A_DBL]); // [RULE8] [RULE9] [RULE10]
      s_nxt.freq_b = rate_hz(cfg.rate[RATE_B_HI:RATE_B_LO],
                             cfg.rate[RATE_B_OVS],
                             cfg.rate[RATE_B_DBL]); // [RULE5] [RULE6] [RULE7]
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_r.regs <= {RST_PDR, RST_RATE, RST_CONV,
                      RST_INTC, RST_REF, RST_OE};
         s_r.rsp <= '0;
         s_r.freq_a <= '0;
         s_r.freq_b <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign rsp_out = s_r.rsp;
   assign synth_a_freq_out = s_r.freq_a;
   assign synth_b_freq_out = s_r.freq_b;

   // ---------------------------------------------
   // Power-down gating
   // ---------------------------------------------
   assign osc_pd_out = cfg.pdr[PDR_OSC_PD];
   assign synth_a_pd_out = cfg.pdr[PDR_A_PD];
   assign synth_b_pd_out = cfg.pdr[PDR_B_PD];
   assign receiver_pd_out = cfg.oe[OE_RX_PD];
   assign xtal_t = ticks_in.crystal & ~osc_pd_out; // [RULE20]
   assign sa_t = ticks_in.synth_a & ~synth_a_pd_out; // [RULE20]
   assign sb_t = ticks_in.synth_b & ~synth_b_pd_out; // [RULE20]
   assign sb3_t = ticks_in.synth_b_fs3 & ~synth_b_pd_out; // [RULE20]
   assign rx512_t = ticks_in.rx_512 & ~receiver_pd_out; // [RULE18]
   assign rx256_t = ticks_in.rx_256 & ~receiver_pd_out; // [RULE18]
   assign mclk_t = ticks_in.master;

   // ---------------------------------------------
   // Dividers
   // ---------------------------------------------
   acs_tick_halver u_half_xtal
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .halve_in (cfg.pdr[PDR_XTAL_HALF]),
      .tick_in  (xtal_t),
      .tick_out (xtal_ref_t)
   ); // [RULE3]
   acs_tick_halver u_half_mout
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .halve_in (cfg.pdr[PDR_MOUT_HALF]),
      .tick_in  (mclk_t),
      .tick_out (master_clock_out_tick_out)
   ); // [RULE2]
   acs_tick_halver u_half_sa
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .halve_in (1'b1),
      .tick_in  (sa_t),
      .tick_out (sa_half_t)
   );
   acs_tick_halver u_half_sb
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .halve_in (1'b1),
      .tick_in  (sb_t),
      .tick_out (sb_half_t)
   );
   acs_tick_halver u_half_sb3
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .halve_in (1'b1),
      .tick_in  (sb3_t),
      .tick_out (sb3_half_t)
   );

   // ---------------------------------------------
   // Clock selection
   // ---------------------------------------------
   assign synth_a_ref_tick_out = cfg.ref_sel[REF_A] ?
                                 mclk_t : xtal_ref_t; // [RULE17]
   assign synth_b_ref_tick_out = cfg.ref_sel[REF_B] ?
                                 mclk_t : xtal_ref_t; // [RULE16]
   assign sa_int_t = cfg.intc[INTC_SA] ? sa_half_t : sa_t; // [RULE15]
   always_comb
   begin
      case (cfg.intc[INTC_SB_HI:INTC_SB_LO]) // [RULE15]
         2'h0: sb_int_t = sb_t;
         2'h1: sb_int_t = sb_half_t;
         2'h2: sb_int_t = sb3_t;
         default: sb_int_t = sb3_half_t;
      endcase
   end
   assign playback_tick_out =
      conv_pick(cfg.conv[CONV_PLAY_HI:CONV_PLAY_LO], xtal_t,
                mclk_t, sa_int_t, sb_int_t,
                rx512_t, rx256_t); // [RULE11]
   assign record_tick_out =
      conv_pick(cfg.conv[CONV_REC_HI:CONV_REC_LO], xtal_t,
                mclk_t, sa_int_t, sb_int_t,
                rx512_t, rx256_t); // [RULE12]
   assign internal_b_tick_out =
      conv_pick({1'b0, cfg.conv[CONV_ICB_HI:CONV_ICB_LO]}, xtal_t,
                mclk_t, sa_int_t, sb_int_t,
                1'b0, 1'b0); // [RULE13]
   assign internal_a_tick_out =
      conv_pick({1'b0, cfg.intc[INTC_ICA_HI:INTC_ICA_LO]}, xtal_t,
                mclk_t, sa_int_t, sb_int_t,
                1'b0, 1'b0); // [RULE14]

   // ---------------------------------------------
   // System clock outputs
   // ---------------------------------------------
   // Reserved route codes behave as synthesizer routing
   assign route = cfg.pdr[PDR_ROUTE_HI:PDR_ROUTE_LO];
   assign sysclk_c_mult_out = cfg.pdr[PDR_C_RATE] ?
                              MULT_256 : MULT_512; // [RULE4]
   assign sc_src_t = (route == ROUTE_RX) ?
      (cfg.pdr[PDR_C_RATE] ? rx256_t : rx512_t) :
      (ticks_in.synth_c & ~synth_b_pd_out); // [RULE1] [RULE4]
   assign sysclk_a_tick_out = sa_int_t & ~cfg.oe[OE_A]; // [RULE19]
   assign sysclk_b_tick_out = sb_int_t & ~cfg.oe[OE_B]; // [RULE19]
   assign sysclk_c_tick_out = sc_src_t & ~cfg.oe[OE_C]; // [RULE19]

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_route_rx: assert property (route == ROUTE_RX // [RULE1]
      && !cfg.oe[OE_C] && !cfg.pdr[PDR_C_RATE] |-> sysclk_c_tick_out ==
      (ticks_in.rx_512 & ~cfg.oe[OE_RX_PD]))
      else $error("clock C not from recovered 512 fs");
   a_route_syn: assert property (route == ROUTE_SYNTH // [RULE1]
      && !cfg.oe[OE_C] && !cfg.pdr[PDR_B_PD]
      |-> sysclk_c_tick_out == ticks_in.synth_c)
      else $error("clock C not from synthesizer");
   a_rate_mult: assert property ( // [RULE4]
      sysclk_c_mult_out == (cfg.pdr[PDR_C_RATE] ? 10'h100 : 10'h200))
      else $error("clock C multiplier wrong");
   a_mout_half: assert property (cfg.pdr[PDR_MOUT_HALF] // [RULE2]
      && $past(cfg.pdr[PDR_MOUT_HALF]) && $past(master_clock_out_tick_out)
      |-> !master_clock_out_tick_out)
      else $error("halved master output ticked twice in a row");
   a_mout_full: assert property (!cfg.pdr[PDR_MOUT_HALF] // [RULE2]
      |-> master_clock_out_tick_out == ticks_in.master)
      else $error("undivided master output mismatch");
   a_xtal_half: assert property (cfg.pdr[PDR_XTAL_HALF] // [RULE3]
      && !cfg.ref_sel[REF_A] && ticks_in.crystal && !osc_pd_out
      ##1 cfg.pdr[PDR_XTAL_HALF] && !cfg.ref_sel[REF_A]
      && ticks_in.crystal && !osc_pd_out
      |-> synth_a_ref_tick_out != $past(synth_a_ref_tick_out))
      else $error("crystal halving not alternating");
   a_freq_a: assert property ( // [RULE8] [RULE9] [RULE10]
      cfg.rate[RATE_A_HI:RATE_A_DBL] == 4'hf ##1 $stable(cfg.rate)
      |-> synth_a_freq_out == 32'h0204cc00)
      else $error("synth A 88.2k at 384 fs wrong");
   a_freq_b48: assert property ( // [RULE5] [RULE6] [RULE7]
      cfg.rate[RATE_B_HI:RATE_B_LO] == 2'h0
      && !cfg.rate[RATE_B_OVS] && !cfg.rate[RATE_B_DBL]
      ##1 $stable(cfg.rate) |-> synth_b_freq_out == 32'h00bb8000)
      else $error("synth B 48k at 256 fs wrong");
   a_play_src: assert property ( // [RULE11]
      cfg.conv[CONV_PLAY_HI:CONV_PLAY_LO] == SRC_MCLK
      |-> playback_tick_out == ticks_in.master)
      else $error("playback not on master clock");
   a_rec_rx: assert property ( // [RULE12] [RULE18]
      cfg.conv[CONV_REC_HI:CONV_REC_LO] == SRC_R512
      |-> record_tick_out == (ticks_in.rx_512 & ~receiver_pd_out))
      else $error("record not on receiver 512 fs");
   a_icb_sel: assert property (cfg.conv[CONV_ICB_HI:CONV_ICB_LO] // [RULE13]
      == 2'h3 |-> internal_b_tick_out == sb_int_t)
      else $error("internal B not on synth B");
   a_ica_sel: assert property (cfg.intc[INTC_ICA_HI:INTC_ICA_LO] // [RULE14]
      == 2'h2 |-> internal_a_tick_out == sa_int_t)
      else $error("internal A not on synth A");
   a_sb_fs3: assert property ( // [RULE15]
      cfg.intc[INTC_SB_HI:INTC_SB_LO] == 2'h2
      |-> sb_int_t == (ticks_in.synth_b_fs3 & ~synth_b_pd_out))
      else $error("synth B internal not on FS3");
   a_ref_sel: assert property (cfg.ref_sel[REF_B] // [RULE16]
      |-> synth_b_ref_tick_out == ticks_in.master)
      else $error("synth B reference not master clock");
   a_ref_a: assert property (cfg.ref_sel[REF_A] // [RULE17]
      |-> synth_a_ref_tick_out == ticks_in.master)
      else $error("synth A reference not master clock");
   a_pd_stop: assert property (synth_a_pd_out // [RULE20]
      |-> !sa_int_t && !sysclk_a_tick_out)
      else $error("powered-down synth A still ticking");
   a_oe_off: assert property (cfg.oe[OE_B] // [RULE19]
      |-> !sysclk_b_tick_out)
      else $error("disabled clock B output ticking");
   a_rd_reserved: assert property (req_in.rd_en // [RULE21]
      && req_in.addr == ADDR_REF |=> rsp_out.rd_valid
      && rsp_out.rd_data[5:0] == 6'h00)
      else $error("reserved reference bits read nonzero");

   c_route_rx: cover property (route == ROUTE_RX && sysclk_c_tick_out);
   c_mout_half: cover property (cfg.pdr[PDR_MOUT_HALF]
      && master_clock_out_tick_out);
   c_play_sb: cover property (
      cfg.conv[CONV_PLAY_HI:CONV_PLAY_LO] == SRC_SB && playback_tick_out);
   c_rd: cover property (rsp_out.rd_valid);
endmodule : acs_clock_control
`default_nettype wire

//--- common/acs_pkg.sv
`default_nettype none
package acs_pkg;
   // ---------------------------------------------
   // Register offsets
   // ---------------------------------------------
   localparam logic [6:0] ADDR_PDR  = 7'h74;
   localparam logic [6:0] ADDR_RATE = 7'h75;
   localparam logic [6:0] ADDR_CONV = 7'h76;
   localparam logic [6:0] ADDR_INTC = 7'h77;
   localparam logic [6:0] ADDR_REF  = 7'h78;
   localparam logic [6:0] ADDR_OE   = 7'h7a;
   // ---------------------------------------------
   // Reset values and writable bits
   // ---------------------------------------------
   localparam logic [7:0] RST_PDR   = 8'h00;
   localparam logic [7:0] RST_RATE  = 8'h00;
   localparam logic [7:0] RST_CONV  = 8'h00;
   localparam logic [7:0] RST_INTC  = 8'h00;
   localparam logic [7:0] RST_REF   = 8'h00;
   localparam logic [7:0] RST_OE    = 8'h07;
   localparam logic [7:0] MASK_INTC = 8'h1f;
   localparam logic [7:0] MASK_REF  = 8'hc0;
   localparam logic [7:0] MASK_OE   = 8'h37;
   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int PDR_ROUTE_HI = 7;
   localparam int PDR_ROUTE_LO = 6;
   localparam int PDR_MOUT_HALF = 5;
   localparam int PDR_XTAL_HALF = 4;
   localparam int PDR_B_PD = 3;
   localparam int PDR_A_PD = 2;
   localparam int PDR_OSC_PD = 1;
   localparam int PDR_C_RATE = 0;
   localparam int RATE_B_HI = 7;
   localparam int RATE_B_LO = 6;
   localparam int RATE_B_OVS = 5;
   localparam int RATE_B_DBL = 4;
   localparam int RATE_A_HI = 3;
   localparam int RATE_A_LO = 2;
   localparam int RATE_A_OVS = 1;
   localparam int RATE_A_DBL = 0;
   localparam int CONV_PLAY_HI = 7;
   localparam int CONV_PLAY_LO = 5;
   localparam int CONV_REC_HI = 4;
   localparam int CONV_REC_LO = 2;
   localparam int CONV_ICB_HI = 1;
   localparam int CONV_ICB_LO = 0;
   localparam int INTC_ICA_HI = 4;
   localparam int INTC_ICA_LO = 3;
   localparam int INTC_SB_HI = 2;
   localparam int INTC_SB_LO = 1;
   localparam int INTC_SA = 0;
   localparam int REF_B = 7;
   localparam int REF_A = 6;
   localparam int OE_RX_PD = 5;
   localparam int OE_A = 2;
   localparam int OE_B = 1;
   localparam int OE_C = 0;
   // ---------------------------------------------
   // Codes and rates
   // ---------------------------------------------
   localparam logic [1:0] ROUTE_SYNTH = 2'h0;
   localparam logic [1:0] ROUTE_RX    = 2'h3;
   localparam logic [2:0] SRC_XTAL = 3'h0;
   localparam logic [2:0] SRC_MCLK = 3'h1;
   localparam logic [2:0] SRC_SA   = 3'h2;
   localparam logic [2:0] SRC_SB   = 3'h3;
   localparam logic [2:0] SRC_R512 = 3'h4;
   localparam logic [2:0] SRC_R256 = 3'h5;
   localparam logic [1:0] BASE_32  = 2'h2;
   localparam logic [1:0] BASE_441 = 2'h3;
   localparam logic [31:0] HZ_48K  = 32'h0000bb80;
   localparam logic [31:0] HZ_32K  = 32'h00007d00;
   localparam logic [31:0] HZ_441K = 32'h0000ac44;
   localparam logic [9:0] MULT_512 = 10'h200;
   localparam logic [9:0] MULT_256 = 10'h100;
   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef struct packed {
      logic [7:0] pdr;
      logic [7:0] rate;
      logic [7:0] conv;
      logic [7:0] intc;
      logic [7:0] ref_sel;
      logic [7:0] oe;
   } acs_regs_type;
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [6:0] addr;
      logic [7:0] wdata;
   } acs_bus_req_type;
   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
   } acs_bus_rsp_type;
   typedef struct packed {
      logic crystal;
      logic master;
      logic synth_a;
      logic synth_b;
      logic synth_b_fs3;
      logic synth_c;
      logic rx_512;
      logic rx_256;
   } acs_ticks_type;
   typedef struct packed {
      acs_regs_type    regs;
      acs_bus_rsp_type rsp;
      logic [31:0]     freq_a;
      logic [31:0]     freq_b;
   } acs_state_type;
   typedef struct packed {
      logic phase;
   } acs_half_state_type;
endpackage : acs_pkg
`default_nettype wire

//--- logic/acs_tick_halver.sv
`default_nettype none
module acs_tick_halver
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Tick path
   input  wire logic halve_in,
   input  wire logic tick_in,
   output logic      tick_out
);
   import acs_pkg::*;

   acs_half_state_type s_r;
   acs_half_state_type s_nxt;

   // Phase parks at zero while bypassed, so a fresh
   // halving always passes the second tick first
   always_comb
   begin
      s_nxt = s_r;
      if (!halve_in)
      begin
         s_nxt.phase = 1'b0;
      end
      else if (tick_in)
      begin
         s_nxt.phase = ~s_r.phase;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign tick_out = halve_in ? (tick_in & s_r.phase) : tick_in;
endmodule : acs_tick_halver
`default_nettype wire

//--- tb/acs_host_model.sv
`default_nettype none
module acs_host_model
(
   // Clock
   input  wire logic                     clk_in,
   // Control port
   output acs_pkg::acs_bus_req_type      req_out,
   input  wire acs_pkg::acs_bus_rsp_type rsp_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import acs_pkg::*;
   // ------------------------------
   // Control port cycles
   // ------------------------------
   initial req_out = '0;
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1 req_out = '{1'b1, 1'b0, a, d};
      @(posedge clk_in);
      #1 req_out = '0;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_in);
      #1 req_out = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_in);
      #1 req_out = '0;
      d = rsp_in.rd_valid ? rsp_in.rd_data : 8'hxx;
   endtask : rd
endmodule : acs_host_model
`default_nettype wire

//--- tb/audio_clock_source_control_tb.sv
`default_nettype none
module audio_clock_source_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acs_pkg::*;
   // ------------------------------
   // Harness
   // ------------------------------
   logic            clk_in;
   logic            rst_n_in;
   acs_bus_req_type req;
   acs_bus_rsp_type rsp;
   acs_ticks_type   ticks;
   logic [31:0]     fa, fb, failures, samples_checked;
   logic [9:0]      mult;
   logic            apd, bpd, opd, rpd, pb, rec, ia, ib;
   logic            mco, aref, bref, sa, sb, sc;
   logic [7:0]      d;
   wire logic [4:0] outs = {mco, aref, bref, ia, ib};
   int              src [8] = '{7, 6, 5, 4, 1, 0, 7, 7};
   acs_host_model acs_host_model_i (.clk_in(clk_in), .req_out(req),
      .rsp_in(rsp));
   acs_clock_control acs_clock_control_i (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .req_in(req), .rsp_out(rsp), .ticks_in(ticks),
      .synth_a_freq_out(fa), .synth_b_freq_out(fb),
      .sysclk_c_mult_out(mult), .synth_a_ref_tick_out(aref),
      .synth_b_ref_tick_out(bref), .synth_a_pd_out(apd),
      .synth_b_pd_out(bpd), .osc_pd_out(opd), .receiver_pd_out(rpd),
      .playback_tick_out(pb), .record_tick_out(rec),
      .internal_a_tick_out(ia), .internal_b_tick_out(ib),
      .master_clock_out_tick_out(mco), .sysclk_a_tick_out(sa),
      .sysclk_b_tick_out(sb), .sysclk_c_tick_out(sc));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      acs_host_model_i.wr(a, v);
   endtask : wr
   task automatic tick(input int j);
      @(posedge clk_in);
      #1 ticks = 8'h01 << j;
      #1;
   endtask : tick
   task automatic t_regs();
      acs_host_model_i.rd(ADDR_OE, d);
      check(d, RST_OE);
      acs_host_model_i.rd(7'h10, d);
      check(d, 8'h00);
      wr(ADDR_INTC, 8'hff);
      acs_host_model_i.rd(ADDR_INTC, d);
      check(d, 8'h1f);
      wr(ADDR_REF, 8'hff);
      acs_host_model_i.rd(ADDR_REF, d);
      check(d, 8'hc0);
      wr(ADDR_OE, 8'hff);
      acs_host_model_i.rd(ADDR_OE, d);
      check(d, 8'h37);
      check(rpd, 1'b1);
      wr(ADDR_OE, 8'h00);
      wr(ADDR_REF, 8'h00);
      check(rpd, 1'b0);
   endtask : t_regs
   task automatic t_rates();
      logic [31:0] bz;
      logic [1:0]  b;
      for (int i = 0; i < 12; i++)
      begin
         b = (i < 4) ? 2'h0 : (i < 8) ? 2'h2 : 2'h3;
         bz = (b == 2'h2) ? HZ_32K : (b == 2'h3) ? HZ_441K : HZ_48K;
         wr(ADDR_RATE, {b, i[1], i[0], b, ~i[1], i[0]});
         @(posedge clk_in);
         #1 check(fa,
                  bz * (i[1] ? 32'h100 : 32'h180) * (i[0] ? 2 : 1));
         check(fb,
               bz * (i[1] ? 32'h180 : 32'h100) * (i[0] ? 2 : 1));
      end
   endtask : t_rates
   task automatic t_sources();
      // Crystal references keep the halver watched
      wr(ADDR_REF, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(ADDR_CONV, {c[2:0], c[2:0], c[1:0]});
         wr(ADDR_INTC, {3'h0, c[1:0], 3'h0});
         for (int j = 0; j < 8; j++)
         begin
            tick(j);
            check(pb, j == src[c]);
            check(rec, j == src[c]);
            check(ia, j == src[c[1:0]]);
            check(ib, j == src[c[1:0]]);
         end
      end
   endtask : t_sources
   task automatic t_route();
      logic [7:0] p [4] = '{8'h00, 8'h01, 8'hc0, 8'hc1};
      int         s [4] = '{2, 2, 1, 0};
      wr(ADDR_CONV, 8'h00);
      wr(ADDR_INTC, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         wr(ADDR_PDR, p[k]);
         check(mult, p[k][0] ? MULT_256 : MULT_512);
         for (int j = 0; j < 8; j++)
         begin
            tick(j);
            check(sc, j == s[k]);
            check({sa, sb}, {j == 5, j == 4});
         end
      end
      wr(ADDR_OE, 8'h07);
      @(posedge clk_in);
      #1 ticks = 8'hff;
      #1 check({sa, sb, sc}, 3'h0);
      wr(ADDR_OE, 8'h00);
      wr(ADDR_PDR, 8'h0e);
      #1 check({apd, bpd, opd, pb, sa, sc}, 6'h38);
      wr(ADDR_PDR, 8'h00);
   endtask : t_route
   task automatic burst(input int j, input logic [31:0] e [5]);
      logic [31:0] n [5];
      n = '{default: 32'h0};
      repeat (4)
      begin
         tick(j);
         for (int k = 0; k < 5; k++)
            n[k] += outs[4 - k];
         tick(8);
      end
      for (int k = 0; k < 5; k++)
         check(n[k], e[k]);
   endtask : burst
   task automatic t_halve();
      wr(ADDR_PDR, 8'h30);
      wr(ADDR_INTC, 8'h15);
      wr(ADDR_CONV, 8'h03);
      burst(7, '{0, 2, 2, 0, 0});
      burst(6, '{2, 0, 0, 0, 0});
      burst(5, '{0, 0, 0, 2, 0});
      burst(3, '{0, 0, 0, 0, 4});
      wr(ADDR_REF, 8'hc0);
      burst(6, '{2, 4, 4, 0, 0});
      wr(ADDR_INTC, 8'h17);
      burst(3, '{0, 0, 0, 0, 2});
      wr(ADDR_INTC, 8'h13);
      burst(4, '{0, 0, 0, 0, 2});
   endtask : t_halve
   task automatic give_verdict();
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // ------------------------------
   // Sequence
   // ------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial
   begin
      #200us;
      failures++;
      give_verdict();
   end
   initial
   begin
      failures = 0;
      samples_checked = 0;
      ticks = 8'h00;
      rst_n_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      t_regs();
      t_halve();
      t_rates();
      t_sources();
      t_route();
      give_verdict();
   end
endmodule : audio_clock_source_control_tb
`default_nettype wire
